//--- ioc_cfg.svh
// Constants for the configurable I/O cell: storage element slots and reset values.
// Assumes inclusion by bare name from every file of the cell.
//
// Overview of operation
// - Three storage elements per cell, each flip-flop or latch by configuration.
// - One shared cell clock, a separate clock enable per element.
// - One shared set/reset, per element sync set, sync reset, async preset or clear.
// - Pad input reaches core directly or through the input storage element.
// - Pad output data comes directly from core or from the output element.
// - Pad output enable comes directly from core or from the enable element.
// - Output buffer and every control signal have their own polarity inversion.
// - Before configuration pads are high impedance, pull-downs and keeper off.
// - Pre-configuration pull-ups are chosen globally by mode input, else pads float.
// - After configuration each pad may enable a pull-up or a pull-down.
// - Selected keeper follows the pad level and holds it when drivers release.
`ifndef IOC_CFG_SVH
`define IOC_CFG_SVH

// ----------------------------------------
// Storage element slots
// ----------------------------------------
`define IOC_NUM_ELEM 3
`define IOC_ELEM_IN 0
`define IOC_ELEM_OUT 1
`define IOC_ELEM_OE 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IOC_Q_RESET 1'b0
`define IOC_PAD_RESET 1'b0

`endif

//--- ioc_pkg.sv
// Types shared by the configurable I/O cell modules.
// Assumes nothing of its surroundings.
package ioc_pkg;

	// ----------------------------------------
	// Set/reset behaviour of one element
	// ----------------------------------------
	typedef enum logic [1:0] {
		SR_SYNC_SET,
		SR_SYNC_RST,
		SR_ASYNC_SET,
		SR_ASYNC_CLR
	} ioc_sr_mode_t;

	// ----------------------------------------
	// User pull selection after configuration
	// ----------------------------------------
	typedef enum logic [1:0] {
		PULL_NONE,
		PULL_UP,
		PULL_DOWN
	} ioc_pull_t;

endpackage : ioc_pkg

//--- ioc_store.sv
// One storage element of the I/O cell: flip-flop or latch with shared set/reset.
// Assumes clock edge and level indications already carry the configured polarity.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_cfg.svh"

module ioc_store (
	// System
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Cell controls, polarity already applied
	input wire logic cell_clk_rise,
	input wire logic cell_clk_lvl,
	input wire logic elem_ce,
	input wire logic sr_act,
	// Configuration
	input wire logic latch_mode,
	input wire ioc_pkg::ioc_sr_mode_t sr_mode,
	// Data
	input wire logic d,
	output logic q
);

	logic q_reg;
	logic q_next;
	logic upd;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Async modes act without a cell clock event; sync modes beat the enable
	always_comb begin
		upd = latch_mode ? cell_clk_lvl : cell_clk_rise;
		q_next = q_reg;
		if (sr_act && sr_mode == ioc_pkg::SR_ASYNC_SET) begin
			q_next = 1'b1;
		end else if (sr_act && sr_mode == ioc_pkg::SR_ASYNC_CLR) begin
			q_next = 1'b0;
		end else if (upd && sr_act && sr_mode == ioc_pkg::SR_SYNC_SET) begin
			q_next = 1'b1;
		end else if (upd && sr_act && sr_mode == ioc_pkg::SR_SYNC_RST) begin
			q_next = 1'b0;
		end else if (upd && elem_ce) begin
			q_next = d;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q_reg <= `IOC_Q_RESET;
		end else if (ce) begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	async_clear_a: assert property (
		ce && sr_act && sr_mode == ioc_pkg::SR_ASYNC_CLR |=> !q)
		else $error("async clear did not clear element");

	sync_set_a: assert property (
		ce && !cell_clk_rise && !latch_mode && sr_act && sr_mode == ioc_pkg::SR_SYNC_SET && !q
		|=> !q)
		else $error("sync set acted without a clock edge");

	latch_hold_a: assert property (
		ce && latch_mode && !cell_clk_lvl && !(sr_act && sr_mode inside {ioc_pkg::SR_ASYNC_SET,
		ioc_pkg::SR_ASYNC_CLR}) |=> $stable(q))
		else $error("closed latch changed value");

	ff_capture_a: assert property (
		ce && !latch_mode && cell_clk_rise && elem_ce && !sr_act |=> q == $past(d))
		else $error("flip-flop failed to capture data");

endmodule : ioc_store
`default_nettype wire

//--- ioc_cell.sv
// Configurable I/O cell: input, output and output-enable paths with storage, pulls and keeper.
// Assumes the pad level arrives asynchronously and core signals share clk.
// Every output is registered, so a direct output path still costs one clk cycle and the direct input path three.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_cfg.svh"

module ioc_cell (
	// System
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Configuration state
	input wire logic cfg_done,
	input wire logic mode_pullup,
	// Per-cell configuration
	input wire logic in_use_store,
	input wire logic out_use_store,
	input wire logic oe_use_store,
	input wire logic [`IOC_NUM_ELEM-1:0] latch_mode,
	input wire ioc_pkg::ioc_sr_mode_t sr_mode [`IOC_NUM_ELEM],
	input wire ioc_pkg::ioc_pull_t pull_sel,
	input wire logic keeper_sel,
	// Polarity inversions
	input wire logic inv_out,
	input wire logic inv_oe,
	input wire logic inv_clk,
	input wire logic [`IOC_NUM_ELEM-1:0] inv_ce,
	input wire logic inv_sr,
	// Core side
	input wire logic cell_clk,
	input wire logic [`IOC_NUM_ELEM-1:0] elem_ce,
	input wire logic shared_set_reset,
	input wire logic core_out,
	input wire logic core_oe,
	output logic core_in,
	// Pad side
	input wire logic pad_i,
	output logic pad_o,
	output logic pad_oe,
	output logic pull_up,
	output logic pull_dn,
	output logic keep_o,
	output logic keep_oe
);

	// ----------------------------------------
	// Pad synchroniser and cell clock edge
	// ----------------------------------------
	logic pad_s1_reg;
	logic pad_s2_reg;
	logic clk_prev_reg;
	logic clk_prev_next;
	logic cell_clk_lvl;
	logic cell_clk_rise;
	logic sr_act;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pad_s1_reg <= `IOC_PAD_RESET;
			pad_s2_reg <= `IOC_PAD_RESET;
		end else if (ce) begin
			pad_s1_reg <= pad_i;
			pad_s2_reg <= pad_s1_reg;
		end
	end

	always_comb begin
		cell_clk_lvl = cell_clk ^ inv_clk;
		cell_clk_rise = cell_clk_lvl && !clk_prev_reg;
		clk_prev_next = cell_clk_lvl;
		sr_act = shared_set_reset ^ inv_sr;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			// Start high: a cell clock already active at release must not count as an edge
			clk_prev_reg <= 1'b1;
		end else if (ce) begin
			clk_prev_reg <= clk_prev_next;
		end
	end

	// ----------------------------------------
	// Storage elements
	// ----------------------------------------
	logic [`IOC_NUM_ELEM-1:0] elem_d;
	logic [`IOC_NUM_ELEM-1:0] elem_q;

	always_comb begin
		elem_d[`IOC_ELEM_IN] = pad_s2_reg;
		elem_d[`IOC_ELEM_OUT] = core_out;
		elem_d[`IOC_ELEM_OE] = core_oe;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `IOC_NUM_ELEM; gi++) begin : g_elem
			ioc_store u_store (
				.clk(clk),
				.resetn(resetn),
				.ce(ce),
				.cell_clk_rise(cell_clk_rise),
				.cell_clk_lvl(cell_clk_lvl),
				.elem_ce(elem_ce[gi] ^ inv_ce[gi]),
				.sr_act(sr_act),
				.latch_mode(latch_mode[gi]),
				.sr_mode(sr_mode[gi]),
				.d(elem_d[gi]),
				.q(elem_q[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Pad and core outputs
	// ----------------------------------------
	logic core_in_reg, core_in_next;
	logic pad_o_reg, pad_o_next;
	logic pad_oe_reg, pad_oe_next;
	logic pull_up_reg, pull_up_next;
	logic pull_dn_reg, pull_dn_next;
	logic keep_o_reg, keep_o_next;
	logic keep_oe_reg, keep_oe_next;
	logic oe_src;

	always_comb begin
		core_in_next = in_use_store ? elem_q[`IOC_ELEM_IN] : pad_s2_reg;
		pad_o_next = (out_use_store ? elem_q[`IOC_ELEM_OUT] : core_out) ^ inv_out;
		oe_src = (oe_use_store ? elem_q[`IOC_ELEM_OE] : core_oe) ^ inv_oe;
		// Keeper tracks the sensed level and only pushes while the own driver is off
		keep_o_next = pad_s2_reg;
		if (cfg_done) begin
			pad_oe_next = oe_src;
			pull_up_next = pull_sel == ioc_pkg::PULL_UP;
			pull_dn_next = pull_sel == ioc_pkg::PULL_DOWN;
			keep_oe_next = keeper_sel && !oe_src;
		end else begin
			// Unconfigured pads float unless the global mode asks for pull-ups
			pad_oe_next = 1'b0;
			pull_up_next = mode_pullup;
			pull_dn_next = 1'b0;
			keep_oe_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			core_in_reg <= 1'b0;
			pad_o_reg <= 1'b0;
			pad_oe_reg <= 1'b0;
			pull_up_reg <= 1'b0;
			pull_dn_reg <= 1'b0;
			keep_o_reg <= 1'b0;
			keep_oe_reg <= 1'b0;
		end else if (ce) begin
			core_in_reg <= core_in_next;
			pad_o_reg <= pad_o_next;
			pad_oe_reg <= pad_oe_next;
			pull_up_reg <= pull_up_next;
			pull_dn_reg <= pull_dn_next;
			keep_o_reg <= keep_o_next;
			keep_oe_reg <= keep_oe_next;
		end
	end

	assign core_in = core_in_reg;
	assign pad_o = pad_o_reg;
	assign pad_oe = pad_oe_reg;
	assign pull_up = pull_up_reg;
	assign pull_dn = pull_dn_reg;
	assign keep_o = keep_o_reg;
	assign keep_oe = keep_oe_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_unconfigured;
		ce && !cfg_done;
	endsequence

	sequence s_released;
		ce && cfg_done && keeper_sel && !oe_src;
	endsequence

	preconf_hiz_a: assert property (
		s_unconfigured |=> !pad_oe && !pull_dn && !keep_oe)
		else $error("pad not released before configuration");

	preconf_pull_a: assert property (
		s_unconfigured |=> pull_up == $past(mode_pullup))
		else $error("pre-configuration pull-up not set by mode");

	in_direct_a: assert property (
		ce ##1 ce ##1 ce && !in_use_store |=> core_in == $past(pad_i, 3))
		else $error("direct input path latency wrong");

	out_path_a: assert property (
		ce && cfg_done |=> pad_o == $past((out_use_store ? elem_q[`IOC_ELEM_OUT] : core_out) ^ inv_out))
		else $error("pad data source or inversion wrong");

	oe_store_a: assert property (
		ce && cfg_done && oe_use_store |=> pad_oe == $past(elem_q[`IOC_ELEM_OE] ^ inv_oe))
		else $error("stored output enable not driven");

	user_pull_a: assert property (
		ce && cfg_done |=> (pull_up && pull_dn) == 1'b0 && pull_dn == $past(pull_sel == ioc_pkg::PULL_DOWN))
		else $error("user pull selection wrong");

	keeper_follow_a: assert property (
		s_released |=> keep_oe && !pad_oe && keep_o == $past(pad_s2_reg))
		else $error("keeper not holding sensed level");

	shared_sr_a: assert property (
		ce && sr_act && sr_mode[`IOC_ELEM_IN] == ioc_pkg::SR_ASYNC_SET
		##1 ce && in_use_store |=> core_in)
		else $error("preset input element not seen on core");

endmodule : ioc_cell
`default_nettype wire

//--- ioc_board_model.sv
// Board model for one pad of the I/O cell: external driver, board pull, floating line.
// Assumes the cell outputs are registered on clk.
`timescale 1ns/1ps
`default_nettype none

module ioc_board_model (
	// Clock
	input wire logic clk,
	// Cell side
	input wire logic pad_o,
	input wire logic pad_oe,
	input wire logic pull_up,
	input wire logic pull_dn,
	input wire logic keep_o,
	input wire logic keep_oe,
	// Board side
	input wire logic ext_en,
	input wire logic ext_val,
	input wire logic ext_pu,
	output logic pad_i
);
	// A floating pad wanders, so a stale level can never pass for a held one
	logic float_reg = 1'h0;

	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end

	always_comb begin
		if (pad_oe) begin
			pad_i = pad_o;
		end else if (ext_en) begin
			pad_i = ext_val;
		end else if (keep_oe) begin
			pad_i = keep_o;
		end else if (pull_up | ext_pu) begin
			pad_i = 1'h1;
		end else if (pull_dn) begin
			pad_i = 1'h0;
		end else begin
			pad_i = float_reg;
		end
	end
endmodule : ioc_board_model

`default_nettype wire

//--- tb_io_cell_storage_paths.sv
// Testbench for the I/O cell: table of direct-path cases, then storage, set/reset and keeper cases.
// Assumes ioc_cell and ioc_board_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_io_cell_storage_paths;
	typedef struct packed {
		logic [6:0] ctl;
		ioc_pkg::ioc_pull_t ps;
		logic [4:0] exp;
	} ioc_row_t;
	logic clk = 1'h0, resetn = 1'h0, ce = 1'h1, cfg = 1'h0, mpu = 1'h0, in_s = 1'h0, out_s = 1'h0, oe_s = 1'h0;
	logic ksel = 1'h0, inv_out = 1'h0, inv_oe = 1'h0, inv_clk = 1'h0, inv_sr = 1'h0, cclk = 1'h0, sr = 1'h0;
	logic co = 1'h0, coe = 1'h0, ext_en = 1'h0, ext_val = 1'h0, ext_pu = 1'h0;
	logic [2:0] lat = 3'h0, inv_ce = 3'h0, ece = 3'h7;
	ioc_pkg::ioc_sr_mode_t srm [3] = '{ioc_pkg::SR_SYNC_RST, ioc_pkg::SR_SYNC_RST, ioc_pkg::SR_SYNC_RST};
	ioc_pkg::ioc_pull_t psel = ioc_pkg::PULL_NONE;
	logic pad_i, core_in, pad_o, pad_oe, pull_up, pull_dn, keep_o, keep_oe;
	int error_cnt = 0, comparisons = 0;
	ioc_row_t rows [6];

	always #12.5 clk = ~clk;

	// ----------------------------------------
	// Cell and board
	// ----------------------------------------
	ioc_cell ioc_cell_inst (.clk(clk), .resetn(resetn), .ce(ce), .cfg_done(cfg), .mode_pullup(mpu),
		.in_use_store(in_s), .out_use_store(out_s), .oe_use_store(oe_s), .latch_mode(lat), .sr_mode(srm),
		.pull_sel(psel), .keeper_sel(ksel), .inv_out(inv_out), .inv_oe(inv_oe), .inv_clk(inv_clk),
		.inv_ce(inv_ce), .inv_sr(inv_sr), .cell_clk(cclk), .elem_ce(ece), .shared_set_reset(sr),
		.core_out(co), .core_oe(coe), .core_in(core_in), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
		.pull_up(pull_up), .pull_dn(pull_dn), .keep_o(keep_o), .keep_oe(keep_oe));
	ioc_board_model ioc_board_model_inst (.clk(clk), .pad_o(pad_o), .pad_oe(pad_oe), .pull_up(pull_up),
		.pull_dn(pull_dn), .keep_o(keep_o), .keep_oe(keep_oe), .ext_en(ext_en), .ext_val(ext_val),
		.ext_pu(ext_pu), .pad_i(pad_i));

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic nclk(input int n);
		repeat (n) @(negedge clk);
	endtask : nclk

	// Cell clock is sampled on clk, so each phase is held several cycles
	task automatic cedge();
		cclk = 1'h1;
		nclk(3);
		cclk = 1'h0;
		nclk(3);
	endtask : cedge

	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#(25 * 4000);
		error_cnt++;
		final_report();
	end

	initial begin
		logic t;
		// Row control bits: cfg_done, mode_pullup, core_out, core_oe, inv_out, inv_oe, keeper_sel
		rows[0] = '{7'h33, ioc_pkg::PULL_DOWN, 5'h14};
		rows[1] = '{7'h08, ioc_pkg::PULL_UP, 5'h00};
		rows[2] = '{7'h58, ioc_pkg::PULL_UP, 5'h1C};
		rows[3] = '{7'h76, ioc_pkg::PULL_DOWN, 5'h0A};
		rows[4] = '{7'h41, ioc_pkg::PULL_NONE, 5'h01};
		rows[5] = '{7'h59, ioc_pkg::PULL_NONE, 5'h18};
		nclk(2);
		chk("reset", {core_in, pad_o, pad_oe, pull_up, pull_dn, keep_o, keep_oe}, 8'h00);
		nclk(1);
		resetn = 1'h1;
		foreach (rows[i]) begin
			{cfg, mpu, co, coe, inv_out, inv_oe, ksel} = rows[i].ctl;
			psel = rows[i].ps;
			nclk(4);
			chk("row", {pad_o, pad_oe, pull_up, pull_dn, keep_oe}, rows[i].exp);
		end
		co = 1'h0;
		nclk(1);
		chk("out_lat", pad_o, 8'h00);
		{coe, ksel, ext_en, ext_val} = 4'h2;
		nclk(5);
		ext_val = 1'h1;
		nclk(2);
		chk("in_early", core_in, 8'h00);
		nclk(1);
		chk("in_lat", core_in, 8'h01);
		in_s = 1'h1;
		ext_val = 1'h0;
		// Let the synchroniser settle so the cell edge captures the new pad level
		nclk(3);
		cedge();
		ext_val = 1'h1;
		nclk(6);
		chk("in_hold", core_in, 8'h00);
		cedge();
		chk("in_cap", core_in, 8'h01);
		ece[0] = 1'h0;
		ext_val = 1'h0;
		cedge();
		chk("in_ce_off", core_in, 8'h01);
		inv_ce[0] = 1'h1;
		cedge();
		chk("in_ce_inv", core_in, 8'h00);
		inv_ce = 3'h0;
		ece = 3'h7;
		inv_clk = 1'h1;
		nclk(4);
		ext_val = 1'h1;
		cclk = 1'h1;
		nclk(5);
		chk("clk_inv_fall", core_in, 8'h00);
		cclk = 1'h0;
		nclk(5);
		chk("clk_inv_rise", core_in, 8'h01);
		inv_clk = 1'h0;
		lat = 3'h1;
		cclk = 1'h1;
		ext_val = 1'h0;
		nclk(6);
		chk("latch_open", core_in, 8'h00);
		cclk = 1'h0;
		nclk(2);
		ext_val = 1'h1;
		nclk(6);
		chk("latch_hold", core_in, 8'h00);
		cclk = 1'h1;
		nclk(6);
		chk("latch_reopen", core_in, 8'h01);
		cclk = 1'h0;
		lat = 3'h0;
		in_s = 1'h0;
		out_s = 1'h1;
		for (int m = 0; m < 4; m++) begin
			t = (m == 0 || m == 2);
			srm[1] = ioc_pkg::ioc_sr_mode_t'(m);
			inv_sr = m[0];
			sr = m[0];
			co = ~t;
			cedge();
			chk("sr_pre", pad_o ^ t, 8'h01);
			ece[1] = 1'h0;
			sr = ~m[0];
			nclk(4);
			chk("sr_async", pad_o ^ t, (m > 1) ? 8'h00 : 8'h01);
			cedge();
			chk("sr_sync", pad_o ^ t, 8'h00);
			sr = m[0];
			ece[1] = 1'h1;
		end
		{out_s, ext_en, oe_s, coe} = 4'h3;
		nclk(4);
		chk("oe_hold", pad_oe, 8'h00);
		cedge();
		chk("oe_cap", pad_oe, 8'h01);
		coe = 1'h0;
		cedge();
		{oe_s, ksel, ext_en, ext_val} = 4'h7;
		nclk(6);
		ext_en = 1'h0;
		nclk(8);
		chk("keep_hi", {keep_oe, keep_o, core_in}, 8'h07);
		{ext_en, ext_val} = 2'h2;
		nclk(6);
		ext_en = 1'h0;
		nclk(8);
		chk("keep_lo", {keep_oe, keep_o, core_in}, 8'h04);
		{cfg, ksel, mpu, ext_pu} = 4'h1;
		nclk(6);
		chk("board_pull", {pull_up, keep_oe, core_in}, 8'h01);
		{ext_pu, ext_en, ext_val} = 3'h2;
		srm[0] = ioc_pkg::SR_ASYNC_SET;
		nclk(4);
		chk("in_pad_lo", core_in, 8'h00);
		{in_s, sr} = 2'h2;
		nclk(3);
		chk("in_preset", core_in, 8'h01);
		// Direct path now sees a low pad, so only a frozen cell keeps the high level
		{ce, in_s} = 2'h0;
		nclk(4);
		chk("ce_freeze", core_in, 8'h01);
		final_report();
	end
endmodule : tb_io_cell_storage_paths

`default_nettype wire
